// ==== verilog/scl_pkg.sv ====
// shared constants for the serial configuration latch bank
package scl_pkg;
    localparam int SCL_WORD_W = 24;
    localparam int SCL_CNT_W = 5;
    // select codes, low bits of each word
    localparam logic [1:0] SCL_SEL_CTRL = 2'h0;
    localparam logic [2:0] SCL_SEL_TX = 3'h1;
    localparam logic [2:0] SCL_SEL_CAL = 3'h5;
    localparam logic [1:0] SCL_SEL_LO = 2'h2;
    localparam logic [1:0] SCL_SEL_FILT = 2'h3;
    // control latch field positions (lsb)
    localparam int SCL_CTL_PD_LSB = 19;
    localparam int SCL_CTL_OSCLVL_LSB = 17;
    localparam int SCL_CTL_PUMP_LSB = 14;
    localparam int SCL_CTL_LOLVL_LSB = 12;
    localparam int SCL_CTL_LOMUTE = 11;
    localparam int SCL_CTL_TXMUTE = 10;
    localparam int SCL_CTL_TRI = 9;
    localparam int SCL_CTL_POL = 8;
    localparam int SCL_CTL_MON_LSB = 5;
    localparam int SCL_CTL_HOLD = 4;
    // required reserved pattern at bits 3:2
    localparam logic [1:0] SCL_CTL_RSVD = 2'h1;
    // transmit / calibration / filter latch fields
    localparam int SCL_PHASE_LSB = 21;
    localparam int SCL_MOD_LSB = 18;
    localparam int SCL_BAND_LSB = 16;
    localparam logic [1:0] SCL_BAND_DIV8 = 2'h3;
    localparam int SCL_REF_LSB = 3;
    localparam int SCL_CAL_TRIG = 15;
    localparam int SCL_CALDIV_LSB = 9;
    localparam int SCL_BOOST_LSB = 3;
    localparam int SCL_FILT_BOOST = 7;
    localparam logic [SCL_WORD_W-1:0] SCL_WORD_ZERO = 24'h000000;
endpackage

// ==== verilog/scl_link_if.sv ====
// three-wire serial write link between host and latch bank
`timescale 1ns/10ps
`default_nettype none
interface scl_link_if;
    logic sclk;
    logic sdata;
    logic load_enable;
    modport host (output sclk, output sdata, output load_enable);
    modport dev (input sclk, input sdata, input load_enable);
endinterface
`default_nettype wire

// ==== verilog/scl_divider.sv ====
// programmable divider making a one-cycle tick every div_value input ticks
`timescale 1ns/10ps
`default_nettype none
module scl_divider #(
    parameter int W = 6
) (
    input wire logic mclk, // clock
    input wire logic rst, // sync reset
    input wire logic tick_in, // input pulse
    input wire logic [W-1:0] div_value, // divisor, 0 stops
    output logic tick_out // divided pulse
);
    logic [W-1:0] count;
    wire wrap = tick_in && (count + W'(1) >= div_value) && (div_value != '0);
    always_ff @(posedge mclk) begin
        if (rst) count <= '0;
        else if (wrap) count <= '0;
        else if (tick_in && div_value != '0) count <= count + W'(1);
    end
    always_ff @(posedge mclk) begin
        if (rst) tick_out <= 1'b0;
        else tick_out <= wrap;
    end
endmodule
`default_nettype wire

// ==== verilog/scl_host.sv ====
// host end: serialises 24-bit words onto the three-wire link
`timescale 1ns/10ps
`default_nettype none
module scl_host import scl_pkg::*; #(
    parameter int HALF = 2
) (
    input wire logic mclk, // clock
    input wire logic rst, // sync reset
    input wire logic [1:0] addr, // 0 data, 1 status
    input wire logic [31:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [31:0] rdata, // read data, next cycle
    scl_link_if.host link // serial link
);
    typedef enum logic [1:0] {SCL_IDLE, SCL_LOW, SCL_HIGH, SCL_LOAD} scl_hstate_t;
    scl_hstate_t state;
    logic [SCL_WORD_W-1:0] shreg;
    logic [SCL_CNT_W-1:0] bits;
    logic [7:0] phase;
    logic [SCL_WORD_W-1:0] word_in;
    wire start = wr && addr == 2'h0 && state == SCL_IDLE;
    wire step = phase >= 8'(HALF - 1);
    // keep reserved and divider bits legal whatever software writes
    always_comb begin
        word_in = wdata[SCL_WORD_W-1:0];
        if (word_in[1:0] == SCL_SEL_CTRL) word_in[3:2] = SCL_CTL_RSVD;
        if (word_in[1:0] == 2'h1) word_in[SCL_BAND_LSB+:2] = SCL_BAND_DIV8;
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= SCL_IDLE;
            phase <= 8'h00;
            bits <= '0;
            shreg <= SCL_WORD_ZERO;
            link.sclk <= 1'b0;
            link.sdata <= 1'b0;
            link.load_enable <= 1'b0;
        end else begin
            phase <= (state == SCL_IDLE || step) ? 8'h00 : phase + 8'h01;
            unique case (state)
                SCL_IDLE: if (start) begin
                    shreg <= word_in;
                    bits <= '0;
                    link.sdata <= word_in[SCL_WORD_W-1];
                    state <= SCL_LOW;
                end
                SCL_LOW: if (step) begin
                    link.sclk <= 1'b1;
                    state <= SCL_HIGH;
                end
                SCL_HIGH: if (step) begin
                    link.sclk <= 1'b0;
                    shreg <= {shreg[SCL_WORD_W-2:0], 1'b0};
                    link.sdata <= shreg[SCL_WORD_W-2];
                    bits <= bits + 5'h01;
                    state <= (bits == 5'(SCL_WORD_W - 1)) ? SCL_LOAD : SCL_LOW;
                end
                SCL_LOAD: begin
                    link.load_enable <= ~link.load_enable;
                    if (link.load_enable) state <= SCL_IDLE;
                end
            endcase
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) rdata <= 32'h00000000;
        else if (rd && addr == 2'h1) rdata <= {31'h00000000, state != SCL_IDLE};
        else rdata <= 32'h00000000;
    end
endmodule
`default_nettype wire

// ==== verilog/scl_device.sv ====
// device end: serial latch bank driving the configured controls
// Functional notes
// - sel x00 writes control latch
// - sel 001 writes transmit latch
// - sel 101 writes calibration latch
// - sel x10 writes oscillator divider latch
// - sel x11 writes receive filter latch
// - four power-down bits disable sections
// - oscillator level from two-bit field
// - pump current from three-bit field
// - lo level from two-bit field
// - lo outputs muted until lock
// - transmit outputs muted until lock
// - tristate bit puts pump high-impedance
// - polarity bit: one positive, zero inverting
// - three-bit field selects monitor signal
// - hold bit resets synthesizer counters
// - host writes reserved bits zero one
// - lo phase field from tx/cal
// - modulation phase field selects mixer drive
// - host writes band divider as eight
// - thirteen-bit reference division ratio
// - cal write with trigger starts calibration
// - six-bit divider clocks calibration
// - boost duration count, zero means manual
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module scl_device import scl_pkg::*; (
    input wire logic mclk, // clock
    input wire logic rst, // sync reset
    input wire logic synth_locked, // lock report
    input wire logic reference_input, // reference tick
    input wire logic [7:0] monitor_sources, // monitor candidates
    scl_link_if.dev link, // serial link
    output logic [3:0] powerdown, // filt, synth, osc, tx
    output logic [1:0] osc_level, // oscillator level
    output logic [2:0] pump_current, // pump current
    output logic [1:0] lo_level, // lo level
    output logic lo_enable, // lo outputs on
    output logic tx_enable, // tx outputs on
    output logic pump_tristate, // pump high-z
    output logic detector_polarity, // polarity
    output logic monitor_output_pin, // monitor out
    output logic synth_counter_hold, // counters held
    output logic [2:0] lo_phase, // lo phase select
    output logic [2:0] mod_phase, // modulation phase
    output logic [12:0] ref_divide, // reference ratio
    output logic [SCL_WORD_W-1:0] lo_divider_word, // oscillator_divider_latch
    output logic [SCL_WORD_W-1:0] filter_word, // filter latch
    output logic cal_start, // calibration pulse
    output logic cal_tick, // calibration clock
    output logic boost_active // hp boost on
);
    logic [SCL_WORD_W-1:0] shreg, ctrl, txw, calw;
    logic sclk_d, le_d;
    logic [5:0] boost_cnt;
    wire sclk_rise = link.sclk && !sclk_d;
    wire le_rise = link.load_enable && !le_d;
    wire [2:0] sel = shreg[2:0];
    wire [SCL_WORD_W-1:0] next_shreg = sclk_rise ? {shreg[SCL_WORD_W-2:0], link.sdata} : shreg;
    // select match; the top select bit only counts for the transmit and calibration latches
    function automatic logic sel_hit(input logic [2:0] code, input logic [2:0] want, input logic use_top);
        sel_hit = (code[1:0] == want[1:0]) && (!use_top || code[2] == want[2]);
    endfunction
    // the five codes are disjoint, so a word lands in exactly one latch
    wire wr_ctrl = le_rise && sel_hit(sel, {1'b0, SCL_SEL_CTRL}, 1'b0);
    wire wr_tx = le_rise && sel_hit(sel, SCL_SEL_TX, 1'b1);
    wire wr_cal = le_rise && sel_hit(sel, SCL_SEL_CAL, 1'b1);
    wire wr_lo = le_rise && sel_hit(sel, {1'b0, SCL_SEL_LO}, 1'b0);
    wire wr_filt = le_rise && sel_hit(sel, {1'b0, SCL_SEL_FILT}, 1'b0);
    wire [5:0] cal_div = calw[SCL_CALDIV_LSB+:6];
    wire [5:0] boost_len = calw[SCL_BOOST_LSB+:6];
    wire cal_tick_w;
    // six-bit calibration divider; host must reach 2 MHz
    scl_divider #(.W(6)) u_caldiv (
        .mclk(mclk),
        .rst(rst),
        .tick_in(reference_input),
        .div_value(cal_div),
        .tick_out(cal_tick_w)
    );
    always_ff @(posedge mclk) begin
        if (rst) begin
            sclk_d <= 1'b0;
            le_d <= 1'b0;
            shreg <= SCL_WORD_ZERO;
        end else begin
            sclk_d <= link.sclk;
            le_d <= link.load_enable;
            shreg <= next_shreg;
        end
    end
    // latches have no documented reset; cleared here only for defined state
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl <= SCL_WORD_ZERO;
            txw <= SCL_WORD_ZERO;
            calw <= SCL_WORD_ZERO;
            lo_divider_word <= SCL_WORD_ZERO;
            filter_word <= SCL_WORD_ZERO;
        end else begin
            if (wr_ctrl) ctrl <= shreg;
            if (wr_tx) txw <= shreg;
            if (wr_cal) calw <= shreg;
            if (wr_lo) lo_divider_word <= shreg;
            if (wr_filt) filter_word <= shreg;
        end
    end
    // phase fields follow whichever of tx or cal latch was written last
    wire [2:0] next_lo_phase = (wr_tx || wr_cal) ? shreg[SCL_PHASE_LSB+:3] : lo_phase;
    wire [2:0] next_mod_phase = (wr_tx || wr_cal) ? shreg[SCL_MOD_LSB+:3] : mod_phase;
    always_ff @(posedge mclk) begin
        if (rst) begin
            lo_phase <= 3'h0;
            mod_phase <= 3'h0;
        end else begin
            lo_phase <= next_lo_phase;
            mod_phase <= next_mod_phase;
        end
    end
    // decoded control fields; registered below so every output leaves a flop
    wire [3:0] next_powerdown = ctrl[SCL_CTL_PD_LSB+:4];
    wire [1:0] next_osc_level = ctrl[SCL_CTL_OSCLVL_LSB+:2];
    wire [2:0] next_pump_current = ctrl[SCL_CTL_PUMP_LSB+:3];
    wire [1:0] next_lo_level = ctrl[SCL_CTL_LOLVL_LSB+:2];
    // a powered-down section stays dark even once lock arrives
    wire next_lo_enable = !ctrl[SCL_CTL_PD_LSB+1] && (!ctrl[SCL_CTL_LOMUTE] || synth_locked);
    wire next_tx_enable = !ctrl[SCL_CTL_PD_LSB] && (!ctrl[SCL_CTL_TXMUTE] || synth_locked);
    wire next_pump_tristate = ctrl[SCL_CTL_TRI];
    wire next_detector_polarity = ctrl[SCL_CTL_POL];
    wire next_monitor = monitor_sources[ctrl[SCL_CTL_MON_LSB+:3]];
    wire next_counter_hold = ctrl[SCL_CTL_HOLD];
    wire [12:0] next_ref_divide = txw[SCL_REF_LSB+:13];
    // one pulse per triggering write; a write with the bit low starts nothing
    wire next_cal_start = wr_cal && shreg[SCL_CAL_TRIG];
    always_ff @(posedge mclk) begin
        if (rst) begin
            powerdown <= 4'h0;
            osc_level <= 2'h0;
        end else begin
            powerdown <= next_powerdown;
            osc_level <= next_osc_level;
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            pump_current <= 3'h0;
            lo_level <= 2'h0;
        end else begin
            pump_current <= next_pump_current;
            lo_level <= next_lo_level;
        end
    end
    // lock is sampled live, so muting lifts one cycle after lock reports
    always_ff @(posedge mclk) begin
        if (rst) begin
            lo_enable <= 1'b0;
            tx_enable <= 1'b0;
        end else begin
            lo_enable <= next_lo_enable;
            tx_enable <= next_tx_enable;
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            pump_tristate <= 1'b0;
            detector_polarity <= 1'b0;
        end else begin
            pump_tristate <= next_pump_tristate;
            detector_polarity <= next_detector_polarity;
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            monitor_output_pin <= 1'b0;
            synth_counter_hold <= 1'b0;
        end else begin
            monitor_output_pin <= next_monitor;
            synth_counter_hold <= next_counter_hold;
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            ref_divide <= 13'h0000;
            cal_start <= 1'b0;
            cal_tick <= 1'b0;
        end else begin
            ref_divide <= next_ref_divide;
            cal_start <= next_cal_start;
            cal_tick <= cal_tick_w;
        end
    end
    // load wins over a tick in the same cycle so a fresh start is never shortened
    wire [5:0] next_boost_cnt = cal_start ? boost_len :
        (cal_tick_w && boost_cnt != 6'h00) ? boost_cnt - 6'h01 : boost_cnt;
    wire next_boost = (boost_len == 6'h00) ? filter_word[SCL_FILT_BOOST] : boost_cnt != 6'h00;
    always_ff @(posedge mclk) begin
        if (rst) begin
            boost_cnt <= 6'h00;
            boost_active <= 1'b0;
        end else begin
            boost_cnt <= next_boost_cnt;
            boost_active <= next_boost;
        end
    end
endmodule
`default_nettype wire

// ==== verif/scl_link_props.sv ====
// wire-level checks of the three-wire serial write link
`timescale 1ns/10ps
`default_nettype none
module scl_link_props #(
    parameter int HALF = 2
) (
    input wire logic mclk, // clock
    input wire logic rst, // sync reset
    input wire logic sclk, // serial clock
    input wire logic sdata, // serial data
    input wire logic load_enable // load strobe
);
    logic sclk_q;
    logic [7:0] run_cnt;
    logic [4:0] rise_cnt;
    wire logic sclk_rise = sclk && !sclk_q;
    wire logic [7:0] run_next = (run_cnt == 8'hFF) ? run_cnt : run_cnt + 8'h01;
    always_ff @(posedge mclk) begin
        if (rst) begin
            sclk_q <= 1'b0;
            run_cnt <= 8'h00;
            rise_cnt <= 5'h00;
        end else begin
            sclk_q <= sclk;
            run_cnt <= (sclk != sclk_q) ? 8'h01 : run_next;
            rise_cnt <= load_enable ? 5'h00 : rise_cnt + 5'(sclk_rise);
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_reset_idle: assert property ($fell(rst) |-> !sclk && !load_enable) else $error("link not idle after reset");
    a_load_single: assert property (load_enable |=> !load_enable) else $error("load strobe longer than one cycle");
    a_load_sclk_low: assert property (load_enable |-> !sclk) else $error("load strobe with serial clock high");
    a_bit_count: assert property ($rose(load_enable) |-> rise_cnt == 5'h18) else $error("word not 24 bits");
    a_high_half: assert property ($fell(sclk) |-> run_cnt == 8'(HALF)) else $error("serial clock high time wrong");
    a_low_half: assert property ($rose(sclk) && rise_cnt != 5'h00 |-> run_cnt == 8'(HALF)) else $error("low time wrong");
    a_data_stable: assert property (sclk |-> $stable(sdata)) else $error("serial data moved while clock high");
    a_frame_gap: assert property ($rose(load_enable) |=> !sclk [*2]) else $error("serial clock right after load");
    cover property ($rose(load_enable));
    cover property ($rose(sclk) && sdata);
    cover property ($fell(sclk) ##1 !sdata);
endmodule
`default_nettype wire

// ==== verif/test_serial_config_latch_bank.sv ====
// self-checking bench: host end driving device end over the serial link
`timescale 1ns/10ps
`default_nettype none
module test_serial_config_latch_bank import scl_pkg::*; ;
    typedef struct packed {logic [23:0] word; logic [83:0] st;} scl_note_t;
    logic mclk, rst, wr, rd, lk_in, ref_in, sclk_q;
    logic [1:0] addr, osc, lol;
    logic [31:0] wdata, rdata, junk, d;
    logic [7:0] mon;
    logic [3:0] pd;
    logic [2:0] pmp, lph, mph;
    logic [12:0] rdv, m_ref;
    logic [23:0] low, flw, shreg, m_ctrl, m_tc, m_lo, m_filt;
    logic lo_en, tx_en, tri_o, pol, mon_o, hold, cs, ct, boost;
    logic [2:0] sels [6] = '{3'h0, 3'h1, 3'h5, 3'h2, 3'h3, 3'h4};
    int fails = 0, num_checks = 0, starts = 0, exp_starts = 0, i, cyc, ticks, first_t, last_t;
    scl_note_t notes[$];
    scl_note_t n;
    wire logic [83:0] obs = {pd, osc, pmp, lol, tri_o, pol, hold, lph, mph, rdv, low, flw, mon_o, lo_en, tx_en};
    scl_link_if link();
    scl_host #(.HALF(2)) u_scl_host(.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .link(link));
    scl_device u_scl_device(.mclk(mclk), .rst(rst), .synth_locked(lk_in), .reference_input(ref_in),
        .monitor_sources(mon), .link(link), .powerdown(pd), .osc_level(osc), .pump_current(pmp), .lo_level(lol),
        .lo_enable(lo_en), .tx_enable(tx_en), .pump_tristate(tri_o), .detector_polarity(pol),
        .monitor_output_pin(mon_o), .synth_counter_hold(hold), .lo_phase(lph), .mod_phase(mph),
        .ref_divide(rdv), .lo_divider_word(low), .filter_word(flw), .cal_start(cs), .cal_tick(ct),
        .boost_active(boost));
    scl_link_props #(.HALF(2)) u_scl_link_props(.mclk(mclk), .rst(rst), .sclk(link.sclk), .sdata(link.sdata),
        .load_enable(link.load_enable));
    task automatic check(input string what, input logic [83:0] seen, input logic [83:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task tally_and_finish;
        if (fails == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task bus_wr(input logic [1:0] a, input logic [31:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task bus_rd(input logic [1:0] a, output logic [31:0] v);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task wait_idle;
        int k;
        d = 32'h1;
        for (k = 0; k < 300 && d[0] !== 1'b0; k++)
            bus_rd(2'h1, d);
        check("idle", 84'(d[0]), 84'h0);
        repeat (4) @(posedge mclk);
    endtask
    task send(input logic [23:0] w0);
        logic [23:0] w;
        logic lk;
        wait_idle();
        w = w0;
        lk = 1'($urandom);
        if (w[1:0] == SCL_SEL_CTRL) begin
            w[3:2] = SCL_CTL_RSVD;
            m_ctrl = w;
        end else if (w[1:0] == SCL_SEL_LO)
            m_lo = w;
        else if (w[1:0] == SCL_SEL_FILT)
            m_filt = w;
        else begin
            w[17:16] = SCL_BAND_DIV8;
            m_tc = w;
            if (w[2:0] == SCL_SEL_TX)
                m_ref = w[15:3];
            else if (w[15])
                exp_starts++;
        end
        notes.push_back(scl_note_t'{w, {m_ctrl[22:12], m_ctrl[9:8], m_ctrl[4], m_tc[23:18], m_ref, m_lo, m_filt,
            mon[m_ctrl[7:5]], !m_ctrl[20] && (!m_ctrl[11] || lk), !m_ctrl[19] && (!m_ctrl[10] || lk)}});
        lk_in <= lk;
        bus_wr(2'h0, {8'h00, w0});
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        sclk_q <= link.sclk;
        if (link.sclk && !sclk_q)
            shreg <= {shreg[22:0], link.sdata};
        if (cs === 1'b1)
            starts <= starts + 1;
    end
    initial begin
        forever begin
            @(posedge mclk iff link.load_enable === 1'b1);
            if (notes.size() == 0) begin
                check("extra_load", 84'h1, 84'h0);
            end else begin
                n = notes.pop_front();
                check("wire_word", 84'(shreg), 84'(n.word));
                repeat (3) @(posedge mclk);
                #1 check("latches", obs, n.st);
            end
        end
    end
    initial begin
        repeat (60000) @(posedge mclk);
        fails++;
        tally_and_finish();
    end
    initial begin
        {rst, wr, rd, addr, wdata, lk_in, ref_in} = 39'h4000000000;
        {m_ctrl, m_tc, m_lo, m_filt, m_ref} = 109'h0;
        junk = $urandom(32'h67e8);
        mon = 8'($urandom);
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1 check("reset_state", obs, {81'h0, mon[0], 2'h3});
        for (i = 0; i < 30; i++)
            send({21'($urandom), sels[i % 6]});
        // second write lands while busy and must vanish
        send(24'h000001);
        bus_wr(2'h0, 32'h00FFFFFF);
        bus_rd(2'h1, d);
        check("busy", 84'(d[0]), 84'h1);
        for (i = 0; i < 3; i++) begin
            bus_rd(2'(i == 0 ? 0 : i + 1), d);
            check("unmapped", 84'(d), 84'h0);
        end
        // zero boost count hands control to the manual bit
        send(24'h008005);
        send(24'h000083);
        wait_idle();
        check("boost_on", 84'(boost), 84'h1);
        send(24'h000003);
        wait_idle();
        check("boost_off", 84'(boost), 84'h0);
        // boost of 3 calibration periods, divider 4, reference held high
        send(24'h00881D);
        wait_idle();
        check("boost_armed", 84'(boost), 84'h1);
        ref_in <= 1'b1;
        cyc = 0;
        ticks = 0;
        first_t = 0;
        last_t = 0;
        while (cyc < 100 && boost === 1'b1) begin
            @(posedge mclk);
            #1 cyc = cyc + 1;
            if (ct === 1'b1) begin
                if (ticks == 0)
                    first_t = cyc;
                last_t = cyc;
                ticks = ticks + 1;
            end
        end
        @(posedge mclk);
        ref_in <= 1'b0;
        check("boost_ticks", 84'(ticks), 84'h3);
        check("tick_spacing", 84'(last_t - first_t), 84'h8);
        check("cal_starts", 84'(starts), 84'(exp_starts));
        tally_and_finish();
    end
endmodule
`default_nettype wire
